// [design/bst_pkg.sv]
package bst_pkg;
    // link generation picks the data bus width: 256 bits gen4 x4, 128 bits gen3 x4
    localparam bit LINK_GEN4 = 1'b1;
    localparam int DATA_W_GEN4 = 256;
    localparam int DATA_W_GEN3 = 128;
    localparam int DATA_W = LINK_GEN4 ? DATA_W_GEN4 : DATA_W_GEN3;
    localparam int STRB_W = DATA_W / 8;
    localparam int DW_PER_BEAT = DATA_W / 32;
    localparam int BUF_DEPTH = 2;

    // request header layout towards the link
    localparam int HDR_W = 128;
    localparam int HDR_TYPE_LSB = 120;
    localparam int HDR_RID_LSB = 104;
    localparam int HDR_FUNC_LSB = 88;
    localparam int HDR_LEN_LSB = 76;
    localparam logic [7:0] TYPE_MRD = 8'h20;
    localparam logic [7:0] TYPE_MWR = 8'h60;

    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_EXOKAY = 2'h1;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] MODE_BAS = 2'h0;
    localparam logic [1:0] MODE_BAM_BAS = 2'h1;
    localparam logic [1:0] MODE_BAM_BAS_DMA = 2'h2;

    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RP_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int STAT_WR_BUSY = 0;
    localparam int STAT_RD_BUSY = 1;
    localparam int STAT_ERR_ATTR = 2;
    localparam int STAT_ERR_LEN = 3;
    localparam int STAT_TLP_PEND = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR_DATA = 3'b001,
        ST_WR_RESP = 3'b010,
        ST_RD_REQ = 3'b011,
        ST_RD_DATA = 3'b100
    } bst_state_t;

    function automatic logic bst_port_present(input logic [1:0] mode);
        return (mode == MODE_BAS) || (mode == MODE_BAM_BAS) || (mode == MODE_BAM_BAS_DMA);
    endfunction
endpackage

// [design/bst_buf2.sv]
`timescale 1ns/1ps
module bst_buf2 import bst_pkg::*; #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [BUF_DEPTH-1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } bst_buf_t;

    bst_buf_t s;
    bst_buf_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != 2'(BUF_DEPTH));
    assign out_valid = (s.cnt != 2'h0);
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = ~s.wp;
        end
        if (pop) begin
            next_s.rp = ~s.rp;
        end
        next_s.cnt = 2'(s.cnt + 2'(push) - 2'(pop));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // bst_buf2

// [design/bst_tlp_hdr.sv]
`timescale 1ns/1ps
module bst_tlp_hdr import bst_pkg::*; (
    input wire logic is_write,
    input wire logic rp_mode,
    input wire logic [63:0] addr,
    input wire logic [7:0] len,
    input wire logic [15:0] user,
    output logic [HDR_W-1:0] hdr
);
    logic [11:0] dw_count;

    // a full 256-beat burst is 2048 dwords, so the count field is 12 bits
    assign dw_count = 12'((32'(len) + 32'd1) * DW_PER_BEAT);

    always_comb begin
        hdr = '0;
        hdr[HDR_TYPE_LSB +: 8] = is_write ? TYPE_MWR : TYPE_MRD;
        if (rp_mode) begin
            hdr[HDR_RID_LSB +: 16] = user;
        end else begin
            hdr[HDR_FUNC_LSB +: 16] = user;
        end
        hdr[HDR_LEN_LSB +: 12] = dw_count;
        hdr[63:0] = addr;
    end
endmodule // bst_tlp_hdr

// [design/bst_bridge.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - each accepted read burst becomes a memory read, each write a memory write
// - data buses are 256 bits for gen4 x4, 128 bits for gen3 x4
// - root port: write sideband becomes the write request's requester id
// - read sideband has same layout; root port uses it as read requester id
// - read response never carries exclusive-okay
// - protection inputs are ignored
// - 4-bit ids; responses and read beats return the request's id
// - length field gives beat count minus one; data carries length plus one beats
// - strobes mark valid byte lanes; only those bytes are written
// - manager marks last write beat; bridge marks last read beat
// - address channels carry the 64-bit address of the first beat
// - port exists only in the three bursting-slave user modes
module bst_bridge import bst_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [3:0] AWID,
    input wire logic [63:0] AWADDR,
    input wire logic [15:0] WR_REQ_FUNCTION_SIDEBAND,
    input wire logic [7:0] AWLEN,
    input wire logic [2:0] AWSIZE,
    input wire logic [1:0] AWBURST,
    input wire logic AWLOCK,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [STRB_W-1:0] WSTRB,
    input wire logic WLAST,
    output logic BVALID,
    input wire logic BREADY,
    output logic [3:0] BID,
    output logic [1:0] WR_RESPONSE_CODE,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [3:0] ARID,
    input wire logic [63:0] ARADDR,
    input wire logic [15:0] RD_REQ_FUNCTION_SIDEBAND,
    input wire logic [7:0] ARLEN,
    input wire logic [2:0] ARSIZE,
    input wire logic [1:0] ARBURST,
    input wire logic ARLOCK,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [3:0] RID,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RD_RESPONSE_CODE,
    output logic RLAST,
    output logic TLP_VALID,
    input wire logic TLP_READY,
    output logic TLP_SOP,
    output logic TLP_LAST,
    output logic [HDR_W-1:0] TLP_HDR,
    output logic [DATA_W-1:0] TLP_DATA,
    output logic [STRB_W-1:0] TLP_BE,
    input wire logic CPL_VALID,
    output logic CPL_READY,
    input wire logic [DATA_W-1:0] CPL_DATA,
    input wire logic [1:0] CPL_STATUS
);
    typedef struct packed {
        bst_state_t state;
        logic [3:0] id;
        logic [15:0] user;
        logic [63:0] addr;
        logic [7:0] len;
        logic [7:0] cnt;
        logic bad;
        logic bvalid;
        logic [1:0] bresp;
        logic tv;
        logic tsop;
        logic tlast;
        logic [HDR_W-1:0] thdr;
        logic [DATA_W-1:0] tdata;
        logic [STRB_W-1:0] tbe;
        logic [1:0] mode;
        logic rp;
        logic err_attr;
        logic err_len;
        logic [15:0] wr_done;
        logic [15:0] rd_done;
        logic ah_wr;
        logic [7:0] ah_addr;
        logic [31:0] hrdata;
    } bst_bridge_t;

    bst_bridge_t s;
    bst_bridge_t next_s;
    logic [HDR_W-1:0] hdr;
    logic [1:0] cpl_resp;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [DATA_W+1:0] buf_out;
    logic port_on;
    logic tlp_free;
    logic aw_take;
    logic ar_take;
    logic w_take;
    logic r_take;
    logic ah_addr_phase;

    bst_tlp_hdr u_hdr (
        .is_write(s.state == ST_WR_DATA),
        .rp_mode(s.rp),
        .addr(s.addr),
        .len(s.len),
        .user(s.user),
        .hdr(hdr)
    );

    // exclusive-okay from the link is folded into slave error
    assign cpl_resp = (CPL_STATUS == RESP_EXOKAY) ? RESP_SLVERR : CPL_STATUS;
    assign buf_in_valid = CPL_VALID && (s.state == ST_RD_DATA);
    assign CPL_READY = buf_in_ready && (s.state == ST_RD_DATA);

    // two-entry buffer keeps completion beats while the manager stalls RREADY
    bst_buf2 #(.W(DATA_W + 2)) u_rbuf (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data({cpl_resp, CPL_DATA}),
        .out_valid(RVALID),
        .out_ready(RREADY),
        .out_data(buf_out)
    );

    assign RDATA = buf_out[DATA_W-1:0];
    assign RD_RESPONSE_CODE = buf_out[DATA_W +: 2];
    assign RID = s.id;
    assign RLAST = (s.cnt == s.len);

    assign port_on = bst_port_present(s.mode);
    assign tlp_free = !s.tv || TLP_READY;
    // writes win when both address channels are valid; reads wait as long as AWVALID stays high
    assign AWREADY = (s.state == ST_IDLE) && port_on;
    assign ARREADY = (s.state == ST_IDLE) && port_on && !AWVALID;
    assign WREADY = (s.state == ST_WR_DATA) && tlp_free;
    assign aw_take = AWVALID && AWREADY;
    assign ar_take = ARVALID && ARREADY;
    assign w_take = WVALID && WREADY;
    assign r_take = RVALID && RREADY;

    assign BVALID = s.bvalid;
    assign BID = s.id;
    assign WR_RESPONSE_CODE = s.bresp;
    assign TLP_VALID = s.tv;
    assign TLP_SOP = s.tsop;
    assign TLP_LAST = s.tlast;
    assign TLP_HDR = s.thdr;
    assign TLP_DATA = s.tdata;
    assign TLP_BE = s.tbe;

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s.hrdata;
    assign ah_addr_phase = HSEL && HREADY && HTRANS[1];

    always_comb begin
        next_s = s;
        // register port; only the low address byte is decoded, so the map aliases
        if (HREADY) begin
            next_s.ah_wr = ah_addr_phase && HWRITE;
        end
        if (ah_addr_phase) begin
            next_s.ah_addr = HADDR[7:0];
            if (!HWRITE) begin
                unique case (HADDR[7:0])
                    REG_CTRL: next_s.hrdata = {29'h0, s.rp, s.mode};
                    REG_STATUS: next_s.hrdata = {27'h0, s.tv, s.err_len, s.err_attr,
                        (s.state == ST_RD_REQ) || (s.state == ST_RD_DATA),
                        (s.state == ST_WR_DATA) || (s.state == ST_WR_RESP)};
                    REG_COUNT: next_s.hrdata = {s.rd_done, s.wr_done};
                    default: next_s.hrdata = 32'h0000_0000;
                endcase
            end
        end
        if (s.ah_wr) begin
            if (s.ah_addr == REG_CTRL) begin
                next_s.mode = HWDATA[CTRL_MODE_LSB +: 2];
                next_s.rp = HWDATA[CTRL_RP_BIT];
            end
            // error flags clear on write-one; a new error below still wins
            if (s.ah_addr == REG_STATUS) begin
                next_s.err_attr = s.err_attr && !HWDATA[STAT_ERR_ATTR];
                next_s.err_len = s.err_len && !HWDATA[STAT_ERR_LEN];
            end
        end

        if (TLP_READY) begin
            next_s.tv = 1'b0;
        end

        unique case (s.state)
            ST_IDLE: begin
                next_s.cnt = 8'h00;
                if (aw_take) begin
                    next_s.state = ST_WR_DATA;
                    next_s.id = AWID;
                    next_s.addr = AWADDR;
                    next_s.len = AWLEN;
                    next_s.user = WR_REQ_FUNCTION_SIDEBAND;
                    // protection and size are not looked at
                    next_s.bad = (AWBURST != BURST_INCR) || AWLOCK;
                    if ((AWBURST != BURST_INCR) || AWLOCK) begin
                        next_s.err_attr = 1'b1;
                    end
                end else if (ar_take) begin
                    next_s.state = ST_RD_REQ;
                    next_s.id = ARID;
                    next_s.addr = ARADDR;
                    next_s.len = ARLEN;
                    next_s.user = RD_REQ_FUNCTION_SIDEBAND;
                    if ((ARBURST != BURST_INCR) || ARLOCK) begin
                        next_s.err_attr = 1'b1;
                    end
                end
            end
            ST_WR_DATA: begin
                if (w_take) begin
                    next_s.tv = 1'b1;
                    next_s.tsop = (s.cnt == 8'h00);
                    next_s.tlast = WLAST;
                    next_s.thdr = hdr;
                    next_s.tdata = WDATA;
                    next_s.tbe = WSTRB;
                    next_s.cnt = 8'(s.cnt + 8'h01);
                    if (WLAST != (s.cnt == s.len)) begin
                        next_s.err_len = 1'b1;
                    end
                    // the burst closes on the beat marked last, even if miscounted
                    if (WLAST) begin
                        next_s.state = ST_WR_RESP;
                        next_s.bvalid = 1'b1;
                        next_s.bresp = s.bad ? RESP_SLVERR : RESP_OKAY;
                    end
                end
            end
            ST_WR_RESP: begin
                if (BREADY) begin
                    next_s.bvalid = 1'b0;
                    next_s.state = ST_IDLE;
                    next_s.wr_done = 16'(s.wr_done + 16'h0001);
                end
            end
            ST_RD_REQ: begin
                // waits for a write beat still held on the link side
                if (tlp_free) begin
                    next_s.tv = 1'b1;
                    next_s.tsop = 1'b1;
                    next_s.tlast = 1'b1;
                    next_s.thdr = hdr;
                    next_s.tdata = '0;
                    next_s.tbe = '0;
                    next_s.state = ST_RD_DATA;
                end
            end
            ST_RD_DATA: begin
                if (r_take) begin
                    next_s.cnt = 8'(s.cnt + 8'h01);
                    if (RLAST) begin
                        next_s.state = ST_IDLE;
                        next_s.rd_done = 16'(s.rd_done + 16'h0001);
                    end
                end
            end
            default: next_s.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
            s.mode <= CTRL_RESET[CTRL_MODE_LSB +: 2];
            s.rp <= CTRL_RESET[CTRL_RP_BIT];
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    a_rresp_no_exok: assert property (RVALID |-> RD_RESPONSE_CODE != RESP_EXOKAY)
        else $error("read response shows exclusive-okay");

    a_port_absent: assert property (!port_on |-> !AWREADY && !ARREADY)
        else $error("address accepted while port absent");

    a_bresp_after_last: assert property (w_take && WLAST |=> BVALID && $stable(BID))
        else $error("write response not raised after last beat");

    a_bvalid_cause: assert property ($rose(BVALID) |-> $past(w_take && WLAST))
        else $error("write response without last beat");

    a_beat_to_tlp: assert property (w_take |=> TLP_VALID && TLP_BE == $past(WSTRB)
        && TLP_DATA == $past(WDATA) && TLP_LAST == $past(WLAST))
        else $error("write beat not forwarded with its strobes");

    a_read_to_mrd: assert property (ar_take |-> ##[2:3] (TLP_VALID && TLP_SOP
        && TLP_HDR[HDR_TYPE_LSB +: 8] == TYPE_MRD))
        else $error("read burst produced no read request");

    a_rp_reqid: assert property (TLP_VALID && s.rp && TLP_SOP
        |-> TLP_HDR[HDR_RID_LSB +: 16] == s.user)
        else $error("requester id differs from sideband");

    a_rid_origin: assert property (ar_take |=> s.id == $past(ARID)
        && (!RVALID || RID == $past(ARID)))
        else $error("read id not from request");

    a_rlast_count: assert property (r_take && RLAST |=> s.state == ST_IDLE
        && s.rd_done == 16'($past(s.rd_done) + 16'h0001))
        else $error("read burst not closed on last beat");

    a_tlp_hold: assert property (TLP_VALID && !TLP_READY |=> TLP_VALID
        && $stable(TLP_HDR) && $stable(TLP_DATA))
        else $error("request beat changed while stalled");
endmodule // bst_bridge

// [verification/bst_mgr_model.sv]
`timescale 1ns/1ps
module bst_mgr_model import bst_pkg::*; (
    input wire logic clk,
    output logic awvalid,
    input wire logic awready,
    output logic [3:0] awid,
    output logic [63:0] awaddr,
    output logic [15:0] awuser,
    output logic [7:0] awlen,
    output logic [1:0] awburst,
    output logic awlock,
    output logic [2:0] awprot,
    output logic wvalid,
    input wire logic wready,
    output logic [DATA_W-1:0] wdata,
    output logic [STRB_W-1:0] wstrb,
    output logic wlast,
    input wire logic bvalid,
    output logic bready,
    input wire logic [3:0] bid,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [3:0] arid,
    output logic [63:0] araddr,
    output logic [15:0] aruser,
    output logic [7:0] arlen,
    output logic [1:0] arburst,
    input wire logic rvalid,
    output logic rready,
    input wire logic [3:0] rid,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rlast
);
    bit slow = 1'b0;
    logic [3:0] got_id[$];
    logic [DATA_W-1:0] got_data[$];
    logic [1:0] got_resp[$];
    logic got_last[$];

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awlock} = '0;
        {awid, awaddr, awuser, awlen, awburst, awprot, wdata, wstrb, wlast} = '0;
        {arid, araddr, aruser, arlen, arburst} = '0;
    end

    task automatic gap();
        if (slow) repeat (3) @(posedge clk);
    endtask

    task automatic clear();
        got_id.delete();
        got_data.delete();
        got_resp.delete();
        got_last.delete();
    endtask

    // beat k carries base+k in every dword; released lines show the inverse
    task automatic write(input logic [3:0] id, input logic [63:0] a, input logic [7:0] len,
            input logic [15:0] u, input logic [1:0] bt, input logic [2:0] pr,
            input logic [31:0] base, input logic [STRB_W-1:0] st,
            output logic [3:0] oid, output logic [1:0] oresp);
        {awvalid, awid, awaddr, awuser, awlen, awburst, awprot} <= {1'b1, id, a, u, len, bt, pr};
        do @(negedge clk); while (!awready);
        @(posedge clk);
        {awvalid, awaddr} <= {1'b0, ~a};
        for (int k = 0; k <= len; k++) begin
            {wvalid, wdata, wstrb, wlast} <= {1'b1, {DW_PER_BEAT{base + 32'(k)}}, st, k == len};
            do @(negedge clk); while (!wready);
            @(posedge clk);
            if (slow || k == len) begin
                {wvalid, wdata} <= {1'b0, ~wdata};
                gap();
            end
        end
        bready <= 1'b1;
        do @(negedge clk); while (!bvalid);
        oid = bid;
        oresp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    // slow mode holds off each read beat so the bridge must buffer
    task automatic read(input logic [3:0] id, input logic [63:0] a, input logic [7:0] len,
            input logic [15:0] u);
        {arvalid, arid, araddr, aruser, arlen, arburst} <= {1'b1, id, a, u, len, BURST_INCR};
        do @(negedge clk); while (!arready);
        @(posedge clk);
        {arvalid, araddr} <= {1'b0, ~a};
        for (int k = 0; k <= len; k++) begin
            gap();
            rready <= 1'b1;
            do @(negedge clk); while (!rvalid);
            got_id.push_back(rid);
            got_data.push_back(rdata);
            got_resp.push_back(rresp);
            got_last.push_back(rlast);
            @(posedge clk);
            if (slow || k == len) rready <= 1'b0;
        end
    endtask
endmodule // bst_mgr_model

// [verification/axi_burst_slave_to_pcie_tlp_tb.sv]
`timescale 1ns/1ps
module axi_burst_slave_to_pcie_tlp_tb import bst_pkg::*;;
    localparam logic [63:0] WA = 64'h0000_0001_0000_0040;
    localparam logic [63:0] RA = 64'h0000_0002_0000_1000;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0, cpl_status = '0, awburst, bresp, arburst, rresp;
    logic awvalid, awready, awlock, wvalid, wready, wlast, bvalid, bready, arvalid, arready;
    logic rvalid, rready, rlast, tlp_valid, tlp_sop, tlp_last, cpl_ready;
    logic tlp_ready = 1'b1, cpl_valid = 1'b0, stall = 1'b0;
    logic [3:0] awid, bid, arid, rid;
    logic [2:0] awprot;
    logic [7:0] awlen, arlen;
    logic [15:0] awuser, aruser;
    logic [63:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, tlp_data, cpl_data = '0;
    logic [STRB_W-1:0] wstrb, tlp_be;
    logic [HDR_W-1:0] tlp_hdr;
    logic [HDR_W-1:0] hq[$];
    logic [DATA_W-1:0] dq[$];
    logic [STRB_W-1:0] bq[$];
    logic [1:0] fq[$];
    bit saw_full = 1'b0;
    int fails = 0, num_checks = 0;

    always #2.5 clk = ~clk;

    bst_bridge dut (
        .REF_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
        .AWVALID(awvalid), .AWREADY(awready), .AWID(awid), .AWADDR(awaddr),
        .WR_REQ_FUNCTION_SIDEBAND(awuser), .AWLEN(awlen), .AWSIZE(3'h5),
        .AWBURST(awburst), .AWLOCK(awlock), .AWPROT(awprot), .WVALID(wvalid),
        .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .WLAST(wlast), .BVALID(bvalid),
        .BREADY(bready), .BID(bid), .WR_RESPONSE_CODE(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARID(arid), .ARADDR(araddr), .RD_REQ_FUNCTION_SIDEBAND(aruser),
        .ARLEN(arlen), .ARSIZE(3'h5), .ARBURST(arburst), .ARLOCK(1'b0), .ARPROT(3'h0),
        .RVALID(rvalid), .RREADY(rready), .RID(rid), .RDATA(rdata),
        .RD_RESPONSE_CODE(rresp), .RLAST(rlast), .TLP_VALID(tlp_valid),
        .TLP_READY(tlp_ready), .TLP_SOP(tlp_sop), .TLP_LAST(tlp_last), .TLP_HDR(tlp_hdr),
        .TLP_DATA(tlp_data), .TLP_BE(tlp_be), .CPL_VALID(cpl_valid), .CPL_READY(cpl_ready),
        .CPL_DATA(cpl_data), .CPL_STATUS(cpl_status)
    );

    bst_mgr_model mgr (
        .clk(clk), .awvalid(awvalid), .awready(awready), .awid(awid), .awaddr(awaddr),
        .awuser(awuser), .awlen(awlen), .awburst(awburst), .awlock(awlock),
        .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .wlast(wlast), .bvalid(bvalid), .bready(bready), .bid(bid), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .arid(arid), .araddr(araddr),
        .aruser(aruser), .arlen(arlen), .arburst(arburst), .rvalid(rvalid),
        .rready(rready), .rid(rid), .rdata(rdata), .rresp(rresp), .rlast(rlast)
    );

    // link side alternates ready while stalling
    always @(posedge clk) begin
        tlp_ready <= stall ? ~tlp_ready : 1'b1;
        if (tlp_valid && tlp_ready) begin
            hq.push_back(tlp_hdr);
            dq.push_back(tlp_data);
            bq.push_back(tlp_be);
            fq.push_back({tlp_sop, tlp_last});
        end
    end

    always @(negedge clk) if (cpl_valid && !cpl_ready) saw_full = 1'b1;

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
        do @(posedge clk); while (!hreadyout);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wr ? wd : hwdata};
        do @(posedge clk); while (!hreadyout);
        rd = hrdata;
    endtask

    task automatic ahbw(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        check({hresp, hreadyout, rd}, {2'b01, e});
    endtask

    task automatic hdr_chk(input logic [7:0] ty, input logic [7:0] len, input logic [15:0] u,
            input logic rp, input logic [63:0] a);
        check(hq[0][HDR_TYPE_LSB +: 8], ty);
        check(hq[0][HDR_RID_LSB +: 16], rp ? u : 16'h0);
        if (!rp) check(hq[0][HDR_FUNC_LSB +: 16], u);
        check(hq[0][HDR_LEN_LSB +: 12], 12'((len + 1) * DW_PER_BEAT));
        check(hq[0][63:0], a);
    endtask

    task automatic wr_case(input logic [3:0] id, input logic [7:0] len, input logic [15:0] u,
            input logic [1:0] bt, input logic [2:0] pr, input logic [1:0] er, input logic rp);
        logic [3:0] oid;
        logic [1:0] oresp;
        hq.delete();
        dq.delete();
        bq.delete();
        fq.delete();
        mgr.write(id, WA, len, u, bt, pr, 32'hA000_0000, 32'hF0F0_00FF, oid, oresp);
        while (dq.size() <= len) @(posedge clk);
        check(oid, id);
        check(oresp, er);
        hdr_chk(TYPE_MWR, len, u, rp, WA);
        check(dq.size(), len + 1);
        for (int k = 0; k <= len; k++) begin
            check(dq[k], {DW_PER_BEAT{32'hA000_0000 + 32'(k)}});
            check(bq[k], 32'hF0F0_00FF);
            check(fq[k], {k == 0, k == len});
        end
    endtask

    task automatic cpl(input int n, input logic [1:0] st);
        wait (hq.size() > 0);
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            {cpl_valid, cpl_data, cpl_status} <= {1'b1, {DW_PER_BEAT{32'hD000_0000 + 32'(k)}}, st};
            do @(negedge clk); while (!cpl_ready);
            @(posedge clk);
        end
        {cpl_valid, cpl_data} <= {1'b0, ~cpl_data};
    endtask

    task automatic rd_case(input logic [3:0] id, input logic [7:0] len, input logic [15:0] u,
            input logic [1:0] st, input logic [1:0] er, input logic rp);
        hq.delete();
        fq.delete();
        mgr.clear();
        fork
            mgr.read(id, RA, len, u);
            cpl(len + 1, st);
        join
        hdr_chk(TYPE_MRD, len, u, rp, RA);
        check(fq[0], 2'b11);
        check(mgr.got_data.size(), len + 1);
        for (int k = 0; k <= len; k++) begin
            check(mgr.got_id[k], id);
            check(mgr.got_data[k], {DW_PER_BEAT{32'hD000_0000 + 32'(k)}});
            check(mgr.got_last[k], k == len);
            check(mgr.got_resp[k], er);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(REG_CTRL, CTRL_RESET);
        rchk(REG_STATUS, 32'h0);
        rchk(REG_COUNT, 32'h0);
        rchk(32'h0C, 32'h0);
        stall <= 1'b1;
        wr_case(4'h5, 8'h3, 16'h1234, BURST_INCR, 3'h7, RESP_OKAY, 1'b0);
        stall <= 1'b0;
        mgr.slow = 1'b1;
        wr_case(4'hA, 8'h0, 16'h8001, 2'h0, 3'h0, RESP_SLVERR, 1'b0);
        rchk(REG_STATUS, 32'h4);
        ahbw(REG_STATUS, 32'h4);
        rchk(REG_STATUS, 32'h0);
        mgr.slow = 1'b0;
        for (int s = 0; s < 3; s++) rd_case(4'h9 + 4'(s), 8'h1, 16'h2345, 2'(s),
            s == 0 ? RESP_OKAY : RESP_SLVERR, 1'b0);
        // reader stalls so the completion buffer must fill and refuse
        mgr.slow = 1'b1;
        rd_case(4'h3, 8'h7, 16'h0011, 2'h0, RESP_OKAY, 1'b0);
        check(saw_full, 1'b1);
        mgr.slow = 1'b0;
        ahbw(REG_CTRL, 32'h4);
        rchk(REG_CTRL, 32'h4);
        wr_case(4'h7, 8'h1, 16'hBEEF, BURST_INCR, 3'h0, RESP_OKAY, 1'b1);
        rd_case(4'h6, 8'h0, 16'hCAFE, 2'h0, RESP_OKAY, 1'b1);
        for (int m = 0; m < 4; m++) begin
            ahbw(REG_CTRL, 32'(m));
            @(posedge clk);
            check(awready, m != 3);
            check(arready, m != 3);
        end
        rchk(REG_COUNT, {16'h5, 16'h3});
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule // axi_burst_slave_to_pcie_tlp_tb
